// *** pfs_pkg.sv ***
// Constants shared by the pin function select block: offsets, fields, codes, masks.
// Assumes byte addresses on the register port and 32-bit register words.
package pfs_pkg;

  // Select register byte addresses
  localparam logic [31:0] P2U_SEL_ADDR  = 32'hE002_C014;
  localparam logic [31:0] P3L_SEL_ADDR  = 32'hE002_C018;
  localparam logic [31:0] P3U_SEL_ADDR  = 32'hE002_C01C;
  localparam logic [31:0] P4L_SEL_ADDR  = 32'hE002_C020;
  localparam logic [31:0] P4U_SEL_ADDR  = 32'hE002_C024;

  // Read-only pad level registers
  localparam logic [31:0] P2_LVL_ADDR   = 32'hE002_C0E0;
  localparam logic [31:0] P3_LVL_ADDR   = 32'hE002_C0E4;
  localparam logic [31:0] P4_LVL_ADDR   = 32'hE002_C0E8;

  // Reset value of every select register and stored bits of the last one
  localparam logic [31:0] SEL_RESET     = 32'h0000_0000;
  localparam int          P4U_BITS      = 6;

  // Select codes
  localparam logic [1:0]  SEL_GPIO      = 2'b00;
  localparam logic [1:0]  SEL_FUNC1     = 2'b01;
  localparam logic [1:0]  SEL_FUNC2     = 2'b10;
  localparam logic [1:0]  SEL_FUNC3     = 2'b11;
  localparam int          FIELD_W       = 2;

  // Pin numbering across the covered pins
  localparam int          NUM_PINS      = 67;
  localparam int          P2_BASE       = 0;
  localparam int          P2_CNT        = 16;
  localparam int          P3_BASE       = 16;
  localparam int          P3_CNT        = 32;
  localparam int          P4_BASE       = 48;
  localparam int          P4_CNT        = 19;

  // Pins on which codes 10 and 11 are legal
  localparam logic [66:0] VALID_FUNC2   = 67'h0_0000_FFFF_0000_CCC0;
  localparam logic [66:0] VALID_FUNC3   = 67'h0_0000_7FFF_0000_CCC0;

  // Output enables of functions that are pure outputs on a pin
  localparam logic [15:0] P2_F2_OE      = 16'hCC00;
  localparam logic [15:0] P3_F2_OE      = 16'hE63F;
  localparam logic [15:0] P3_F3_OE      = 16'h7F21;

endpackage

// *** pfs_pin_cell.sv ***
// One pad cell: synchroniser, function select mux and registered pad drive.
// Assumes peripheral and GPIO signals arrive on core_clk; the pad input is asynchronous.
`timescale 1ns/10ps
`default_nettype none

module pfs_pin_cell #(
  parameter logic VALID2     = 1'b0,
  parameter logic VALID3     = 1'b0,
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [1:0] sel,
  input  wire logic       gpio_out,
  input  wire logic       gpio_dir,
  input  wire logic [3:1] func_out,
  input  wire logic [3:1] func_oe,
  input  wire logic       pad_in,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            level,
  output logic [3:1]      func_in
);

  logic       sync1_r;
  logic       sync2_r;
  logic       pad_out_r;
  logic       pad_oe_r;
  logic [3:1] func_in_r;
  logic [3:1] hit;
  logic       out_nxt;
  logic       oe_nxt;

  // Which function the field picks; reserved codes pick nothing
  assign hit[1] = (sel == pfs_pkg::SEL_FUNC1);
  assign hit[2] = (sel == pfs_pkg::SEL_FUNC2) && VALID2;  // see R13
  assign hit[3] = (sel == pfs_pkg::SEL_FUNC3) && VALID3;  // see R13

  // Direction bit only counts under GPIO, else the peripheral drives enable
  assign out_nxt = (sel == pfs_pkg::SEL_GPIO) ? gpio_out :     // see R01
                   (|(hit & func_out));
  assign oe_nxt  = (sel == pfs_pkg::SEL_GPIO) ? gpio_dir :     // see R02
                   (|(hit & func_oe));                         // see R03

  // Two-flop synchroniser, pad drive and routed inputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r   <= 1'b0;
      sync2_r   <= 1'b0;
      pad_out_r <= 1'b0;
      pad_oe_r  <= 1'b0;
      func_in_r <= 3'b000;
    end else begin
      sync1_r   <= pad_in;
      sync2_r   <= sync1_r;
      pad_out_r <= out_nxt;
      pad_oe_r  <= oe_nxt;
      func_in_r <= (hit & {3{sync2_r}}) | (~hit & {3{IDLE_LEVEL}});  // see R01
    end
  end

  assign pad_out = pad_out_r;
  assign pad_oe  = pad_oe_r;
  assign level   = sync2_r;
  assign func_in = func_in_r;

endmodule

`default_nettype wire

// *** pfs_pin_mux.sv ***
// Pin function multiplexer for port 2 pins 16-31, port 3 and port 4 pins 0-18.
// Assumes a single-cycle register port and peripherals clocked on core_clk.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R01: Two-bit field routes pin; 00 means GPIO.
// R02: GPIO direction bit drives enable under GPIO.
// R03: Peripheral sets enable, direction bit ignored.
// R04: Port 3 low pins carry data bits.
// R05: Port 2 high pins carry SDRAM controls.
// R06: P2.22/23: timer3 capture or SPI clock/select.
// R07: P2.26/27: timer3 match or SPI data.
// R08: P2.30/31: timer3 match or I2C lines.
// R09: Port 3 high pins carry data 16-31.
// R10: P3.16-21: PWM0 outputs or UART signals.
// R11: P3.22-31: captures, matches, UART, PWM1.
// R12: Port 4 low pins carry address 0-18.
// R13: Software avoids reserved codes; nothing driven.
module pfs_pin_mux #(
  parameter int NUM_PINS = 67
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Fast GPIO
  input  wire logic [15:0] fast_port2_direction,
  input  wire logic [31:0] fast_port3_direction,
  input  wire logic [18:0] fast_port4_direction,
  input  wire logic [15:0] gpio2_out,
  input  wire logic [31:0] gpio3_out,
  input  wire logic [18:0] gpio4_out,
  output logic [15:0]      gpio2_in,
  output logic [31:0]      gpio3_in,
  output logic [18:0]      gpio4_in,
  // External memory controller
  input  wire logic        sdram_col_strobe,
  input  wire logic        sdram_row_strobe,
  input  wire logic [1:0]  sdram_clock_out,
  input  wire logic [3:0]  dynamic_chip_select,
  input  wire logic [3:0]  sdram_clock_enable,
  input  wire logic [3:0]  sdram_byte_mask,
  input  wire logic [31:0] mem_data_out,
  input  wire logic [31:0] mem_data_oe,
  output logic [31:0]      mem_data_in,
  input  wire logic [18:0] mem_addr,
  // Timers and PWM
  output logic [1:0]       timer3_capture_in,
  input  wire logic [3:0]  timer3_match_out,
  output logic [1:0]       timer0_capture_in,
  input  wire logic [1:0]  timer0_match_out,
  output logic [1:0]       timer1_capture_in,
  input  wire logic [2:0]  timer1_match_out,
  input  wire logic [5:0]  pwm_unit0_output,
  output logic             pwm_unit0_capture,
  input  wire logic [5:0]  pwm_unit1_output,
  output logic             pwm_unit1_capture,
  // First SPI: bit 0 clock, 1 select, 2 master-in, 3 master-out
  input  wire logic [3:0]  spi_a_out,
  input  wire logic [3:0]  spi_a_oe,
  output logic [3:0]       spi_a_in,
  // Third I2C: bit 0 data, 1 clock
  input  wire logic [1:0]  i2c_c_out,
  input  wire logic [1:0]  i2c_c_oe,
  output logic [1:0]       i2c_c_in,
  // Second UART
  input  wire logic        uart_b_transmit,
  output logic             uart_b_receive,
  output logic             uart_b_clear_to_send,
  output logic             uart_b_carrier_detect,
  output logic             uart_b_set_ready,
  input  wire logic        uart_b_terminal_ready,
  output logic             uart_b_ring_indicator,
  input  wire logic        uart_b_request_to_send,
  // Pads
  input  wire logic [66:0] pad_in,
  output logic [66:0]      pad_out,
  output logic [66:0]      pad_oe
);

  // Refuse a pin count that the fixed tables do not describe
  if (NUM_PINS != pfs_pkg::NUM_PINS) begin : g_bad_count
    $error("pfs_pin_mux: NUM_PINS must match the covered pin count");
  end

  logic [31:0]                p2u_sel_r;
  logic [31:0]                p3l_sel_r;
  logic [31:0]                p3u_sel_r;
  logic [31:0]                p4l_sel_r;
  logic [pfs_pkg::P4U_BITS-1:0] p4u_sel_r;
  logic [31:0]                rdata_r;
  logic [31:0]                rdata_nxt;
  logic [133:0]               sel_all;
  logic [66:0]                gpio_out_all;
  logic [66:0]                gpio_dir_all;
  logic [66:0]                fo1;
  logic [66:0]                fe1;
  logic [66:0]                fo2;
  logic [66:0]                fe2;
  logic [66:0]                fo3;
  logic [66:0]                fe3;
  logic [66:0]                fi1;
  logic [66:0]                fi2;
  logic [66:0]                fi3;
  logic [66:0]                lvl;

  // Address decode of the register port
  logic hit_p2u;
  logic hit_p3l;
  logic hit_p3u;
  logic hit_p4l;
  logic hit_p4u;
  logic hit_l2;
  logic hit_l3;
  logic hit_l4;
  assign hit_p2u = (reg_addr == pfs_pkg::P2U_SEL_ADDR);
  assign hit_p3l = (reg_addr == pfs_pkg::P3L_SEL_ADDR);
  assign hit_p3u = (reg_addr == pfs_pkg::P3U_SEL_ADDR);
  assign hit_p4l = (reg_addr == pfs_pkg::P4L_SEL_ADDR);
  assign hit_p4u = (reg_addr == pfs_pkg::P4U_SEL_ADDR);
  assign hit_l2  = (reg_addr == pfs_pkg::P2_LVL_ADDR);
  assign hit_l3  = (reg_addr == pfs_pkg::P3_LVL_ADDR);
  assign hit_l4  = (reg_addr == pfs_pkg::P4_LVL_ADDR);

  // Select registers, all fields clear to GPIO at reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      p2u_sel_r <= pfs_pkg::SEL_RESET;                            // see R04
      p3l_sel_r <= pfs_pkg::SEL_RESET;                            // see R04
      p3u_sel_r <= pfs_pkg::SEL_RESET;
      p4l_sel_r <= pfs_pkg::SEL_RESET;
      p4u_sel_r <= pfs_pkg::SEL_RESET[pfs_pkg::P4U_BITS-1:0];
    end else if (reg_wr) begin
      if (hit_p2u) p2u_sel_r <= reg_wdata;
      if (hit_p3l) p3l_sel_r <= reg_wdata;
      if (hit_p3u) p3u_sel_r <= reg_wdata;
      if (hit_p4l) p4l_sel_r <= reg_wdata;
      if (hit_p4u) p4u_sel_r <= reg_wdata[pfs_pkg::P4U_BITS-1:0];
    end
  end

  // Read mux; unmapped addresses and unused bits read zero
  assign rdata_nxt =
    hit_p2u ? p2u_sel_r :
    hit_p3l ? p3l_sel_r :
    hit_p3u ? p3u_sel_r :
    hit_p4l ? p4l_sel_r :
    hit_p4u ? {26'h000_0000, p4u_sel_r} :
    hit_l2  ? {16'h0000, lvl[pfs_pkg::P2_BASE +: pfs_pkg::P2_CNT]} :
    hit_l3  ? lvl[pfs_pkg::P3_BASE +: pfs_pkg::P3_CNT] :
    hit_l4  ? {13'h0000, lvl[pfs_pkg::P4_BASE +: pfs_pkg::P4_CNT]} :
    32'h0000_0000;

  // Read data stand for the one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= reg_rd ? rdata_nxt : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_r;

  // Fields laid out pin by pin, two bits per covered pin
  assign sel_all      = {p4u_sel_r[5:0], p4l_sel_r, p3u_sel_r, p3l_sel_r, p2u_sel_r};  // see R01
  assign gpio_out_all = {gpio4_out, gpio3_out, gpio2_out};
  assign gpio_dir_all = {fast_port4_direction, fast_port3_direction,
                         fast_port2_direction};                                   // see R02

  // Function 01: memory controller signals in pin order
  assign fo1[15:0]  = {sdram_byte_mask, sdram_clock_enable, dynamic_chip_select,
                       sdram_clock_out, sdram_row_strobe, sdram_col_strobe};      // see R05
  assign fe1[15:0]  = 16'hFFFF;
  assign fo1[47:16] = mem_data_out;                                               // see R04
  assign fe1[47:16] = mem_data_oe;                                                // see R09
  assign fo1[66:48] = mem_addr;                                                   // see R12
  assign fe1[66:48] = 19'h7_FFFF;

  // Function 10: timer and PWM signals
  assign fo2[15:0]  = {timer3_match_out[3:2], 2'b00, timer3_match_out[1:0],
                       10'h000};                                                  // see R07
  assign fe2[15:0]  = pfs_pkg::P2_F2_OE;                                          // see R08
  assign fo2[31:16] = 16'h0000;
  assign fe2[31:16] = 16'h0000;
  assign fo2[47:32] = {timer1_match_out, 2'b00, timer0_match_out, 3'b000,
                       pwm_unit0_output};                                         // see R10
  assign fe2[47:32] = pfs_pkg::P3_F2_OE;                                          // see R11
  assign fo2[66:48] = 19'h0_0000;                                                 // see R12
  assign fe2[66:48] = 19'h0_0000;

  // Function 11: SPI, I2C, UART and PWM1 signals
  assign fo3[15:0]  = {i2c_c_out[1], i2c_c_out[0], 2'b00, spi_a_out[3], spi_a_out[2],
                       2'b00, spi_a_out[1], spi_a_out[0], 6'h00};                 // see R06
  assign fe3[15:0]  = {i2c_c_oe[1], i2c_c_oe[0], 2'b00, spi_a_oe[3], spi_a_oe[2],
                       2'b00, spi_a_oe[1], spi_a_oe[0], 6'h00};                   // see R08
  assign fo3[31:16] = 16'h0000;
  assign fe3[31:16] = 16'h0000;
  assign fo3[47:32] = {1'b0, uart_b_request_to_send, pwm_unit1_output, 2'b00,
                       uart_b_terminal_ready, 4'h0, uart_b_transmit};             // see R11
  assign fe3[47:32] = pfs_pkg::P3_F3_OE;                                          // see R10
  assign fo3[66:48] = 19'h0_0000;
  assign fe3[66:48] = 19'h0_0000;

  // One pad cell per covered pin
  for (genvar i = 0; i < pfs_pkg::NUM_PINS; i++) begin : g_pin
    pfs_pin_cell #(
      .VALID2     (pfs_pkg::VALID_FUNC2[i]),
      .VALID3     (pfs_pkg::VALID_FUNC3[i]),
      .IDLE_LEVEL (1'b0)
    ) u_cell (
      .core_clk (core_clk),
      .rst      (rst),
      .sel      (sel_all[pfs_pkg::FIELD_W*i +: pfs_pkg::FIELD_W]),
      .gpio_out (gpio_out_all[i]),
      .gpio_dir (gpio_dir_all[i]),
      .func_out ({fo3[i], fo2[i], fo1[i]}),
      .func_oe  ({fe3[i], fe2[i], fe1[i]}),
      .pad_in   (pad_in[i]),
      .pad_out  (pad_out[i]),
      .pad_oe   (pad_oe[i]),
      .level    (lvl[i]),
      .func_in  ({fi3[i], fi2[i], fi1[i]})
    );
  end

  // Synchronised pad levels to the GPIO readers
  assign gpio2_in = lvl[pfs_pkg::P2_BASE +: pfs_pkg::P2_CNT];
  assign gpio3_in = lvl[pfs_pkg::P3_BASE +: pfs_pkg::P3_CNT];
  assign gpio4_in = lvl[pfs_pkg::P4_BASE +: pfs_pkg::P4_CNT];

  // Routed inputs to the peripherals
  assign mem_data_in           = fi1[47:16];                  // see R09
  assign timer3_capture_in     = fi2[7:6];                    // see R06
  assign spi_a_in              = {fi3[11:10], fi3[7:6]};      // see R07
  assign i2c_c_in              = fi3[15:14];                  // see R08
  assign uart_b_receive        = fi3[33];                     // see R10
  assign uart_b_clear_to_send  = fi3[34];
  assign uart_b_carrier_detect = fi3[35];
  assign uart_b_set_ready      = fi3[36];
  assign uart_b_ring_indicator = fi3[38];                     // see R11
  assign pwm_unit0_capture     = fi2[38];
  assign pwm_unit1_capture     = fi3[39];
  assign timer0_capture_in     = fi2[40:39];
  assign timer1_capture_in     = fi2[44:43];

endmodule

`default_nettype wire

// *** pfs_pad_model.sv ***
// Pad side model: wire level seen by the mux from its own drive and the outside world.
// Assumes the bench supplies the level that outside parts drive onto undriven pads.
`timescale 1ns/10ps
`default_nettype none

module pfs_pad_model (
  input  wire logic [66:0] pad_out,
  input  wire logic [66:0] pad_oe,
  input  wire logic [66:0] ext_level,
  output logic [66:0]      pad_in
);
  // Driven pads read back their drive, released pads the outside level
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

`default_nettype wire

// *** pfs_pin_mux_asserts.sv ***
// Checker for the pin function multiplexer; shadows select registers from the port.
// Assumes it is bound to pfs_pin_mux and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module pfs_pin_mux_asserts (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] fast_port2_direction,
  input wire logic [15:0] gpio2_out,
  input wire logic        sdram_col_strobe,
  input wire logic [31:0] mem_data_out,
  input wire logic [31:0] mem_data_oe,
  input wire logic [3:0]  timer3_match_out,
  input wire logic [5:0]  pwm_unit0_output,
  input wire logic [1:0]  timer3_capture_in,
  input wire logic [66:0] pad_in,
  input wire logic [66:0] pad_out,
  input wire logic [66:0] pad_oe
);
  logic [31:0] p2u_r;
  logic [31:0] p3l_r;
  logic [31:0] p3u_r;

  // Shadow copies of three select registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      p2u_r <= pfs_pkg::SEL_RESET;
      p3l_r <= pfs_pkg::SEL_RESET;
      p3u_r <= pfs_pkg::SEL_RESET;
    end else if (reg_wr) begin
      if (reg_addr == pfs_pkg::P2U_SEL_ADDR) p2u_r <= reg_wdata;
      if (reg_addr == pfs_pkg::P3L_SEL_ADDR) p3l_r <= reg_wdata;
      if (reg_addr == pfs_pkg::P3U_SEL_ADDR) p3u_r <= reg_wdata;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Capture selection held long enough for the input pipeline
  sequence s_cap_held;
    (p2u_r[13:12] == 2'b10) [*4];
  endsequence

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not idle");
  a_gpio_dir: assert property (p2u_r[1:0] == 2'b00 |=>
    pad_oe[0] == $past(fast_port2_direction[0]) && pad_out[0] == $past(gpio2_out[0]))
    else $error("gpio pin drive wrong");
  a_sdram_strobe: assert property (p2u_r[1:0] == 2'b01 |=>
    pad_oe[0] && pad_out[0] == $past(sdram_col_strobe)) else $error("strobe pin wrong");
  a_data_pin: assert property (p3l_r[1:0] == 2'b01 |=>
    pad_oe[16] == $past(mem_data_oe[0])
    && (!pad_oe[16] || pad_out[16] == $past(mem_data_out[0]))) else $error("data pin wrong");
  a_reserved_off: assert property (p3l_r[1:0] == 2'b11 |=> !pad_oe[16] && !pad_out[16])
    else $error("reserved pin driven");
  a_match_out: assert property (p2u_r[21:20] == 2'b10 |=>
    pad_oe[10] && pad_out[10] == $past(timer3_match_out[0])) else $error("match pin wrong");
  a_pwm_out: assert property (p3u_r[1:0] == 2'b10 |=>
    pad_oe[32] && pad_out[32] == $past(pwm_unit0_output[0])) else $error("pwm pin wrong");
  a_capture_in: assert property (s_cap_held |->
    timer3_capture_in[0] == $past(pad_in[6], 3)) else $error("capture input wrong");
endmodule

bind pfs_pin_mux pfs_pin_mux_asserts chk_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .fast_port2_direction, .gpio2_out, .sdram_col_strobe, .mem_data_out,
  .mem_data_oe, .timer3_match_out, .pwm_unit0_output, .timer3_capture_in, .pad_in, .pad_out,
  .pad_oe);

`default_nettype wire

// *** pfs_pin_mux_bench.sv ***
// Testbench for the pin function multiplexer: register tasks, then one pass per select code.
// Assumes the pad model closes the loop between pad drive and pad level.
`timescale 1ns/10ps
`default_nettype none

module pfs_pin_mux_bench;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] pat = '0;
  logic [66:0] dir_all = '0;
  logic [31:0] reg_rdata, mem_data_in, gpio3_in, rd_v, exp_v;
  logic [66:0] pad_in, pad_out, pad_oe, ext, oe_x, out_x, lvl_x;
  logic [1:0]  timer3_capture_in, timer0_capture_in, timer1_capture_in, i2c_c_in;
  logic        uart_b_receive, pwm_unit1_capture, pwm_unit0_capture;
  logic [15:0] gpio2_in;
  logic [18:0] gpio4_in;
  logic [3:0]  spi_a_in;
  // UART control inputs: clear to send, carrier, set ready, ring
  wire logic [3:0] uart_ctl;
  logic [31:0] sel_a [5] = '{pfs_pkg::P2U_SEL_ADDR, pfs_pkg::P3L_SEL_ADDR,
    pfs_pkg::P3U_SEL_ADDR, pfs_pkg::P4L_SEL_ADDR, pfs_pkg::P4U_SEL_ADDR};
  int          error_cnt = 0;
  int          n_checks = 0;

  always #20 core_clk = ~core_clk;
  // Outside level on released pads
  assign ext = {~pat[2:0], ~pat, pat};

  pfs_pin_mux dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fast_port2_direction(dir_all[15:0]), .fast_port3_direction(dir_all[47:16]),
    .fast_port4_direction(dir_all[66:48]), .gpio2_out(~pat[15:0]), .gpio3_out(pat),
    .gpio4_out(pat[18:0]), .gpio2_in, .gpio3_in, .gpio4_in,
    .sdram_col_strobe(pat[0]), .sdram_row_strobe(pat[1]), .sdram_clock_out(pat[3:2]),
    .dynamic_chip_select(pat[7:4]), .sdram_clock_enable(pat[11:8]),
    .sdram_byte_mask(pat[15:12]), .mem_data_out(pat), .mem_data_oe({pat[15:0], pat[31:16]}),
    .mem_data_in, .mem_addr(~pat[18:0]), .timer3_capture_in, .timer3_match_out(pat[19:16]),
    .timer0_capture_in, .timer0_match_out(pat[21:20]), .timer1_capture_in,
    .timer1_match_out(pat[24:22]), .pwm_unit0_output(pat[30:25]), .pwm_unit0_capture,
    .pwm_unit1_output(~pat[5:0]), .pwm_unit1_capture, .spi_a_out(~pat[11:8]),
    .spi_a_oe(pat[15:12]), .spi_a_in, .i2c_c_out(~pat[17:16]), .i2c_c_oe(pat[19:18]),
    .i2c_c_in, .uart_b_transmit(pat[31]), .uart_b_receive,
    .uart_b_clear_to_send(uart_ctl[0]), .uart_b_carrier_detect(uart_ctl[1]),
    .uart_b_set_ready(uart_ctl[2]), .uart_b_terminal_ready(~pat[6]),
    .uart_b_ring_indicator(uart_ctl[3]), .uart_b_request_to_send(~pat[7]),
    .pad_in, .pad_out, .pad_oe);

  pfs_pad_model pad_u (.pad_out, .pad_oe, .ext_level(ext), .pad_in);

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Writes one code to every select register, then lets the pipelines settle
  task automatic mode(input logic [31:0] v, input logic [31:0] p, input logic [66:0] dr);
    @(posedge core_clk);
    pat <= p;
    dir_all <= dr;
    for (int i = 0; i < 5; i++) wr(sel_a[i], v);
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [66:0] e, input logic [66:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(sel_a[i], rd_v);
      chk("sel reset", 67'h0, rd_v);
      wr(sel_a[i], 32'hC3A5_96F0 + i);
      rd(sel_a[i], rd_v);
      exp_v = (i == 4) ? (32'hC3A5_96F0 + i) & 32'h0000_003F : 32'hC3A5_96F0 + i;
      chk("sel back", exp_v, rd_v);
    end
    wr(32'hE002_C028, 32'hFFFF_FFFF);
    rd(32'hE002_C028, rd_v);
    chk("unmapped", 67'h0, rd_v);
    // All pins as GPIO
    mode(32'h0000_0000, 32'h9C3E_61A5, 67'h5_0F0F_3355_A5A5_5A5A);
    chk("gpio oe", dir_all, pad_oe);
    out_x = {pat[18:0], pat, ~pat[15:0]};
    // Pad level as the pad model makes it: own drive or outside level
    lvl_x = (dir_all & out_x) | (~dir_all & ext);
    chk("gpio out", out_x, pad_out);
    chk("gpio3 in", lvl_x[47:16], gpio3_in);
    chk("gpio2 in", lvl_x[15:0], gpio2_in);
    chk("gpio4 in", lvl_x[66:48], gpio4_in);
    chk("idle in", 67'h0, mem_data_in);
    rd(pfs_pkg::P2_LVL_ADDR, rd_v);
    chk("lvl2 reg", lvl_x[15:0], rd_v);
    rd(pfs_pkg::P3_LVL_ADDR, rd_v);
    chk("lvl3 reg", lvl_x[47:16], rd_v);
    rd(pfs_pkg::P4_LVL_ADDR, rd_v);
    chk("lvl4 reg", lvl_x[66:48], rd_v);
    // Code 01 with direction bits low
    mode(32'h5555_5555, 32'h3C5A_A5C3, 67'h0);
    oe_x = {19'h7_FFFF, pat[15:0], pat[31:16], 16'hFFFF};
    out_x = {~pat[18:0], pat, pat[15:0]};
    lvl_x = (oe_x & out_x) | (~oe_x & ext);
    chk("f1 oe", oe_x, pad_oe);
    chk("f1 out", out_x, pad_out);
    chk("mem in", lvl_x[47:16], mem_data_in);
    // Code 10 with direction bits high
    mode(32'hAAAA_AAAA, 32'h6B1D_E247, {67{1'b1}});
    oe_x = {19'h0, 16'hE63F, 16'h0000, 16'hCC00};
    out_x = '0;
    out_x[11:10] = pat[17:16];
    out_x[15:14] = pat[19:18];
    out_x[37:32] = pat[30:25];
    out_x[42:41] = pat[21:20];
    out_x[47:45] = pat[24:22];
    chk("f2 oe", oe_x, pad_oe);
    chk("f2 out", out_x, pad_out & oe_x);
    chk("t3 cap", ext[7:6], timer3_capture_in);
    chk("t0 cap", ext[40:39], timer0_capture_in);
    chk("t1 cap", ext[44:43], timer1_capture_in);
    chk("pwm0 cap", ext[38], pwm_unit0_capture);
    // Code 11, reserved on port 3 pin 31
    mode(32'hFFFF_FFFF, 32'h52E8_1B9D, {67{1'b1}});
    oe_x = '0;
    oe_x[7:6] = pat[13:12];
    oe_x[11:10] = pat[15:14];
    oe_x[15:14] = pat[19:18];
    oe_x[47:32] = 16'h7F21;
    out_x = '0;
    out_x[7:6] = ~pat[9:8];
    out_x[11:10] = ~pat[11:10];
    out_x[15:14] = ~pat[17:16];
    out_x[32] = pat[31];
    out_x[37] = ~pat[6];
    out_x[45:40] = ~pat[5:0];
    out_x[46] = ~pat[7];
    chk("f3 oe", oe_x, pad_oe);
    chk("f3 out", out_x, pad_out);
    chk("uart rx", ext[33], uart_b_receive);
    chk("pwm1 cap", ext[39], pwm_unit1_capture);
    lvl_x = (oe_x & out_x) | (~oe_x & ext);
    chk("spi in", {lvl_x[11:10], lvl_x[7:6]}, spi_a_in);
    chk("i2c in", lvl_x[15:14], i2c_c_in);
    chk("uart ctl", {ext[38], ext[36:34]}, uart_ctl);
    // Reset again in mid-run
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(sel_a[0], rd_v);
    chk("sel rst2", 67'h0, rd_v);
    chk("oe rst2", dir_all, pad_oe);
    print_verdict();
  end
endmodule

`default_nettype wire
